// file: design/acm_params.svh
// Constants for the accumulator core: address map, register offsets, field positions
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH

// ----------------------------------------
// Program address map
// ----------------------------------------
`define ACM_ROM_BASE 13'h0800
`define ACM_NVM_BYTES 2048
`define ACM_NVM_BLOCK_BYTES 512
`define ACM_NVM_BLOCKS 4
`define ACM_PROG_BASE 13'h0030
`define ACM_PROG_BYTES 1952
`define ACM_USER_BASE 11'h7d0
`define ACM_USER_CELLS 16

// ----------------------------------------
// Configuration copy and RAM map
// ----------------------------------------
`define ACM_CFG_WORDS 16
`define ACM_CFG_BYTES_PER_WORD 3
`define ACM_CFG_LOW_LAST 4'hc
`define ACM_CFG_HIGH_SKIP 7'h03
`define ACM_CFG_RAM_BASE 7'h30
`define ACM_CFG18_RAM 7'h42
`define ACM_RAM_WORDS 127
`define ACM_RAM_LAST 7'h7e
`define ACM_STATUS_RAM 7'h16
`define ACM_CAUSE_MSB 19
`define ACM_CAUSE_LSB 15
`define ACM_CAUSE_POWER 5'h10
`define ACM_GAIN_MSB 23
`define ACM_GAIN_LSB 16

// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define ACM_OFS_CMD 12'h000
`define ACM_OFS_IMM 12'h004
`define ACM_OFS_ACC_X 12'h008
`define ACM_OFS_ACC_Y 12'h00c
`define ACM_OFS_ACC_Z 12'h010
`define ACM_OFS_PTR 12'h014
`define ACM_OFS_FLAGS 12'h018
`define ACM_OFS_PC 12'h01c
`define ACM_OFS_NVM_ADDR 12'h020
`define ACM_OFS_NVM_DATA 12'h024
`define ACM_OFS_STATUS 12'h028
`define ACM_OFS_ACC_RAM 12'h02c
`define ACM_IDX_CFG18 12'h042
`define ACM_OFS_CFG18 12'h108

`endif

// file: design/acm_pkg.sv
// Types shared by the accumulator core
package acm_pkg;

  typedef enum logic [4:0] {
    ACM_OP_NOP = 5'h00,
    ACM_OP_MOVE = 5'h01,
    ACM_OP_SWAP = 5'h02,
    ACM_OP_ADD = 5'h03,
    ACM_OP_SUB = 5'h04,
    ACM_OP_SHR = 5'h05,
    ACM_OP_SHL = 5'h06,
    ACM_OP_ROR = 5'h07,
    ACM_OP_MUL = 5'h08,
    ACM_OP_LDI = 5'h09,
    ACM_OP_PTR_LD = 5'h0a,
    ACM_OP_PTR_INC = 5'h0b,
    ACM_OP_PTR_DEC = 5'h0c,
    ACM_OP_PUT = 5'h0d,
    ACM_OP_GET = 5'h0e,
    ACM_OP_JUMP = 5'h0f,
    ACM_OP_JCOND = 5'h10,
    ACM_OP_ENTER = 5'h11
  } acm_op_e;

  typedef enum logic [1:0] {
    ACM_BOOT_COPY = 2'b01,
    ACM_BOOT_RUN = 2'b10
  } acm_boot_e;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] dst;
    acm_op_e op;
  } acm_cmd_s;

  typedef struct packed {
    logic carry;
    logic ovf;
    logic sign;
    logic not_equal;
  } acm_flags_s;

endpackage : acm_pkg

// file: design/acm_core.sv
// Accumulator core: program map, config copy, RAM pointer, accumulators, flags, APB slave
// Operation
// RULE_01 - ROM routine region begins at program address 2048.
// RULE_02 - Nonvolatile store is 2048 bytes in four 512-byte blocks.
// RULE_03 - Program code occupies 1952 nonvolatile bytes starting at byte 48.
// RULE_04 - Entering nonvolatile code from ROM always starts fetching at 48.
// RULE_05 - Entry cause is recorded in status RAM word 22.
// RULE_06 - Lowest 48 bytes form 16 configuration words, three bytes each.
// RULE_07 - Words go to configuration registers 0 to 12 and 16 to 18.
// RULE_08 - After reset the words are copied into RAM 48 to 66.
// RULE_09 - Put and get reach user cells 2000 to 2047 by index 0 to 15.
// RULE_10 - RAM has its own pointer over 127 words of 24 bits.
// RULE_11 - RAM word under the pointer acts as a fourth accumulator.
// RULE_12 - Moving the pointer leaves every RAM word unchanged.
// RULE_13 - Pointer changes only through load, increment and decrement opcodes.
// RULE_14 - Three 24-bit accumulators X, Y and Z.
// RULE_15 - Transfers and arithmetic accept any of the four accumulators.
// RULE_16 - Not-equal and sign flags update on every accumulator write.
// RULE_17 - Carry and overflow also update on add, subtract and shifts.
// RULE_18 - Each of the four flags can be tested by a conditional jump.
// RULE_19 - Carry holds add/subtract carry-out or the bit shifted out.
// RULE_20 - Config register 18 lives at RAM 66, from bytes 45-47, gain on top.
// RULE_21 - Sign flag is set when the written result has MSB one.
// RULE_22 - Not-equal flag goes to zero when a nonzero result is written.
// RULE_23 - Overflow flag marks signed overflow of add or subtract.
// RULE_24 - Reset clears accumulators, pointer and flags before the copy.
`timescale 1ns/1ps
`include "acm_params.svh"

module acm_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output acm_pkg::acm_flags_s flags,
  output logic rom_region,
  output logic boot_done,
  output logic [7:0] nonlinearity_gain_field
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] nvm [0:`ACM_NVM_BYTES-1]; // see RULE_02
  logic [23:0] ram [0:`ACM_RAM_WORDS-1]; // see RULE_10
  logic [23:0] acc_x;
  logic [23:0] acc_y;
  logic [23:0] acc_z;
  logic [6:0] ram_ptr;
  logic [12:0] pc;
  logic [23:0] imm;
  logic [10:0] nvm_addr;
  acm_pkg::acm_boot_e boot_state;
  logic [3:0] copy_cnt;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic addr_hit;
  logic cmd_fire;
  acm_pkg::acm_cmd_s cmd;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;
  assign cmd = acm_pkg::acm_cmd_s'(pwdata[8:0]);
  always_comb begin
    case (paddr)
      `ACM_OFS_CMD, `ACM_OFS_IMM, `ACM_OFS_ACC_X, `ACM_OFS_ACC_Y, `ACM_OFS_ACC_Z,
      `ACM_OFS_PTR, `ACM_OFS_FLAGS, `ACM_OFS_PC, `ACM_OFS_NVM_ADDR,
      `ACM_OFS_NVM_DATA, `ACM_OFS_STATUS, `ACM_OFS_ACC_RAM, `ACM_OFS_CFG18: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  // Commands are refused until the config copy is over; an error answer never executes
  assign cmd_fire = apb_wr && (paddr == `ACM_OFS_CMD) && boot_done && !pslverr;
  // ----------------------------------------
  // Operand fetch and ALU
  // ----------------------------------------
  function automatic logic [23:0] acc_read(input logic [1:0] sel, input logic [23:0] x,
                                           input logic [23:0] y, input logic [23:0] z,
                                           input logic [23:0] r);
    case (sel)
      2'h0: acc_read = x;
      2'h1: acc_read = y;
      2'h2: acc_read = z;
      default: acc_read = r; // see RULE_11
    endcase
  endfunction : acc_read
  logic [23:0] ram_at_ptr;
  logic [23:0] opa;
  logic [23:0] opb;
  logic [23:0] res;
  logic [23:0] res_src;
  logic [24:0] sum;
  logic [47:0] prod;
  logic wr_dst;
  logic wr_src;
  logic upd_cv;
  logic next_carry;
  logic next_ovf;
  logic [10:0] user_byte;
  logic [10:0] cfg_byte;
  logic [6:0] cfg_ram;
  logic flag_hit;
  assign ram_at_ptr = ram[ram_ptr];
  assign opa = acc_read(cmd.dst, acc_x, acc_y, acc_z, ram_at_ptr); // see RULE_15
  assign opb = acc_read(cmd.src, acc_x, acc_y, acc_z, ram_at_ptr);
  // User cell index maps onto three bytes above the user base
  assign user_byte = `ACM_USER_BASE + {6'h00, imm[3:0], 1'b0} + {7'h00, imm[3:0]}; // see RULE_09
  always_comb begin
    res = opb;
    res_src = opa;
    sum = 25'h0000000;
    prod = {24'h000000, opa} * {24'h000000, opb};
    wr_dst = 1'b0;
    wr_src = 1'b0;
    upd_cv = 1'b0;
    next_carry = flags.carry;
    next_ovf = flags.ovf;
    if (cmd_fire) begin
      case (cmd.op)
        acm_pkg::ACM_OP_MOVE: wr_dst = 1'b1;
        acm_pkg::ACM_OP_SWAP: begin
          wr_dst = 1'b1;
          wr_src = (cmd.dst != cmd.src);
        end
        acm_pkg::ACM_OP_ADD: begin
          sum = {1'b0, opa} + {1'b0, opb};
          res = sum[23:0];
          wr_dst = 1'b1;
          upd_cv = 1'b1;
          next_carry = sum[24]; // see RULE_19
          next_ovf = (opa[23] == opb[23]) && (sum[23] != opa[23]); // see RULE_23
        end
        acm_pkg::ACM_OP_SUB: begin
          sum = {1'b0, opa} - {1'b0, opb};
          res = sum[23:0];
          wr_dst = 1'b1;
          upd_cv = 1'b1;
          next_carry = sum[24]; // see RULE_19
          next_ovf = (opa[23] != opb[23]) && (sum[23] != opa[23]); // see RULE_23
        end
        acm_pkg::ACM_OP_SHR: begin
          res = {opa[23], opa[23:1]};
          wr_dst = 1'b1;
          upd_cv = 1'b1;
          next_carry = opa[0]; // see RULE_19
          next_ovf = 1'b0;
        end
        acm_pkg::ACM_OP_SHL: begin
          res = {opa[22:0], 1'b0};
          wr_dst = 1'b1;
          upd_cv = 1'b1;
          next_carry = opa[23];
          next_ovf = opa[23] ^ opa[22];
        end
        acm_pkg::ACM_OP_ROR: begin
          // Rotates through carry so no bit is lost
          res = {flags.carry, opa[23:1]};
          wr_dst = 1'b1;
          upd_cv = 1'b1;
          next_carry = opa[0];
          next_ovf = 1'b0;
        end
        acm_pkg::ACM_OP_MUL: begin
          res = prod[23:0];
          wr_dst = 1'b1;
        end
        acm_pkg::ACM_OP_LDI: begin
          res = imm;
          wr_dst = 1'b1;
        end
        acm_pkg::ACM_OP_GET: begin
          res = {nvm[user_byte], nvm[user_byte + 11'h001], nvm[user_byte + 11'h002]};
          wr_dst = 1'b1;
        end
        default: wr_dst = 1'b0;
      endcase
    end
  end
  // ----------------------------------------
  // Configuration copy after reset
  // ----------------------------------------
  // Word k sits in bytes 3k..3k+2, first byte most significant
  assign cfg_byte = {6'h00, copy_cnt, 1'b0} + {7'h00, copy_cnt}; // see RULE_06
  // Words 13..15 skip registers 13..15 and land on 16..18
  assign cfg_ram = `ACM_CFG_RAM_BASE + {3'h0, copy_cnt} +
                   ((copy_cnt > `ACM_CFG_LOW_LAST) ? `ACM_CFG_HIGH_SKIP : 7'h00); // see RULE_07
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_state <= acm_pkg::ACM_BOOT_COPY;
      copy_cnt <= 4'h0;
      boot_done <= 1'b0;
    end else begin
      case (boot_state)
        acm_pkg::ACM_BOOT_COPY: begin
          copy_cnt <= copy_cnt + 4'h1;
          if (copy_cnt == 4'hf) begin
            boot_state <= acm_pkg::ACM_BOOT_RUN;
            boot_done <= 1'b1;
          end
        end
        acm_pkg::ACM_BOOT_RUN: boot_done <= 1'b1;
        default: begin
          boot_state <= acm_pkg::ACM_BOOT_COPY;
          copy_cnt <= 4'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Nonvolatile store and RAM writes
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (apb_wr && (paddr == `ACM_OFS_NVM_DATA)) nvm[nvm_addr] <= pwdata[7:0];
    if (cmd_fire && (cmd.op == acm_pkg::ACM_OP_PUT)) begin
      nvm[user_byte] <= opb[23:16]; // see RULE_09
      nvm[user_byte + 11'h001] <= opb[15:8];
      nvm[user_byte + 11'h002] <= opb[7:0];
    end
  end
  // Pointer moves never write here; only the copy, register 18 writes, entry and data operations do
  always_ff @(posedge pclk) begin // see RULE_12
    if (boot_state == acm_pkg::ACM_BOOT_COPY) begin
      ram[cfg_ram] <= {nvm[cfg_byte], nvm[cfg_byte + 11'h001], nvm[cfg_byte + 11'h002]}; // see RULE_08
      if (copy_cnt == 4'hf) begin
        ram[`ACM_STATUS_RAM][`ACM_CAUSE_MSB:`ACM_CAUSE_LSB] <= `ACM_CAUSE_POWER; // see RULE_05
      end
    end else begin
      if (apb_wr && (paddr == `ACM_OFS_CFG18)) begin
        ram[`ACM_CFG18_RAM] <= pwdata[23:0]; // see RULE_20
      end
      if (cmd_fire && (cmd.op == acm_pkg::ACM_OP_ENTER) && rom_region) begin
        ram[`ACM_STATUS_RAM][`ACM_CAUSE_MSB:`ACM_CAUSE_LSB] <= imm[4:0]; // see RULE_05
      end
      if (wr_dst && (cmd.dst == 2'h3)) ram[ram_ptr] <= res; // see RULE_11
      if (wr_src && (cmd.src == 2'h3)) ram[ram_ptr] <= res_src;
    end
  end

  // ----------------------------------------
  // Accumulators, pointer and flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_x <= 24'h000000; // see RULE_24
      acc_y <= 24'h000000;
      acc_z <= 24'h000000;
    end else begin
      if (wr_dst && (cmd.dst == 2'h0)) acc_x <= res; // see RULE_14
      if (wr_dst && (cmd.dst == 2'h1)) acc_y <= res;
      if (wr_dst && (cmd.dst == 2'h2)) acc_z <= res;
      if (wr_src && (cmd.src == 2'h0)) acc_x <= res_src;
      if (wr_src && (cmd.src == 2'h1)) acc_y <= res_src;
      if (wr_src && (cmd.src == 2'h2)) acc_z <= res_src;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_ptr <= 7'h00; // see RULE_24
    end else if (cmd_fire) begin
      case (cmd.op)
        acm_pkg::ACM_OP_PTR_LD: ram_ptr <= (imm[6:0] > `ACM_RAM_LAST) ? `ACM_RAM_LAST : imm[6:0];
        acm_pkg::ACM_OP_PTR_INC: ram_ptr <= (ram_ptr == `ACM_RAM_LAST) ? 7'h00 : ram_ptr + 7'h01;
        acm_pkg::ACM_OP_PTR_DEC: ram_ptr <= (ram_ptr == 7'h00) ? `ACM_RAM_LAST : ram_ptr - 7'h01;
        default: ram_ptr <= ram_ptr; // see RULE_13
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0; // see RULE_24
    end else if (wr_dst) begin
      flags.not_equal <= (res == 24'h000000); // see RULE_16 see RULE_22
      flags.sign <= res[23]; // see RULE_21
      if (upd_cv) begin
        flags.carry <= next_carry; // see RULE_17
        flags.ovf <= next_ovf;
      end
    end
  end

  // ----------------------------------------
  // Program counter and regions
  // ----------------------------------------
  always_comb begin
    case (cmd.src)
      2'h0: flag_hit = flags.not_equal; // see RULE_18
      2'h1: flag_hit = flags.sign;
      2'h2: flag_hit = flags.carry;
      default: flag_hit = flags.ovf;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= `ACM_ROM_BASE;
      rom_region <= 1'b1;
    end else begin
      rom_region <= (pc >= `ACM_ROM_BASE); // see RULE_01
      if ((boot_state == acm_pkg::ACM_BOOT_COPY) && (copy_cnt == 4'hf)) begin
        pc <= `ACM_PROG_BASE; // see RULE_03
      end else if (cmd_fire && (cmd.op == acm_pkg::ACM_OP_ENTER) && rom_region) begin
        pc <= `ACM_PROG_BASE; // see RULE_04
      end else if (cmd_fire && (cmd.op == acm_pkg::ACM_OP_JUMP)) begin
        pc <= imm[12:0];
      end else if (cmd_fire && (cmd.op == acm_pkg::ACM_OP_JCOND) && flag_hit) begin
        pc <= imm[12:0];
      end
    end
  end

  // ----------------------------------------
  // APB registers and answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm <= 24'h000000;
      nvm_addr <= 11'h000;
    end else begin
      if (apb_wr && (paddr == `ACM_OFS_IMM)) imm <= pwdata[23:0];
      if (apb_wr && (paddr == `ACM_OFS_NVM_ADDR)) nvm_addr <= pwdata[10:0];
    end
  end
  // One access cycle after setup; read data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && (!addr_hit || (pwrite && (paddr == `ACM_OFS_CMD) && !boot_done));
      if (apb_setup && !pwrite) begin
        case (paddr)
          `ACM_OFS_IMM: prdata <= {8'h00, imm};
          `ACM_OFS_ACC_X: prdata <= {8'h00, acc_x};
          `ACM_OFS_ACC_Y: prdata <= {8'h00, acc_y};
          `ACM_OFS_ACC_Z: prdata <= {8'h00, acc_z};
          `ACM_OFS_PTR: prdata <= {25'h0000000, ram_ptr};
          `ACM_OFS_FLAGS: prdata <= {28'h0000000, flags};
          `ACM_OFS_PC: prdata <= {19'h00000, pc};
          `ACM_OFS_NVM_ADDR: prdata <= {21'h000000, nvm_addr};
          `ACM_OFS_NVM_DATA: prdata <= {24'h000000, nvm[nvm_addr]};
          `ACM_OFS_STATUS: prdata <= {30'h00000000, rom_region, boot_done};
          `ACM_OFS_ACC_RAM: prdata <= {8'h00, ram_at_ptr};
          `ACM_OFS_CFG18: prdata <= {8'h00, ram[`ACM_CFG18_RAM]};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
  // Mirrors the gain field one cycle behind any RAM write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nonlinearity_gain_field <= 8'h00;
    end else begin
      nonlinearity_gain_field <= ram[`ACM_CFG18_RAM][`ACM_GAIN_MSB:`ACM_GAIN_LSB]; // see RULE_20
    end
  end
endmodule : acm_core

// file: tb/acm_core_chk.sv
// Port-level assertions for the accumulator core
`timescale 1ns/1ps
`include "acm_params.svh"

module acm_core_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire acm_pkg::acm_flags_s flags,
  input wire logic rom_region,
  input wire logic boot_done,
  input wire logic [7:0] nonlinearity_gain_field
);
  // Saturates so the copy length stays measurable after long runs
  logic [4:0] since_rst;
  wire acc = psel && penable && pready;
  wire cmd_ok = acc && pwrite && !pslverr && paddr == `ACM_OFS_CMD;
  wire cfg_ok = acc && pwrite && !pslverr && paddr == `ACM_OFS_CFG18;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst <= 5'h00;
    end else if (since_rst != 5'h1f) begin
      since_rst <= since_rst + 5'h01;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------
  // Checks
  // --------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (psel && !penable && !pwrite && paddr > `ACM_OFS_CFG18
    |=> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
  a_cmd_refused: assert property (psel && !penable && pwrite && paddr == `ACM_OFS_CMD
    && !boot_done |=> pslverr) else $error("command taken before boot");
  a_boot_sixteen: assert property ($rose(boot_done) |-> since_rst == 5'h10)
    else $error("copy length wrong");
  a_rom_until_boot: assert property (!boot_done |-> rom_region)
    else $error("left rom region early");
  a_entry_after_boot: assert property ($rose(boot_done) |-> rom_region ##1 !rom_region)
    else $error("no entry into program area");
  a_flags_at_boot: assert property (!boot_done |-> flags == 4'h0)
    else $error("flags not clear");
  a_flags_cause: assert property ($changed(flags) |-> $past(cmd_ok))
    else $error("flags changed without command");
  a_gain_follow: assert property (cfg_ok
    |=> ##1 nonlinearity_gain_field == $past(pwdata[23:16], 2)) else $error("gain field stale");

  c_cmd: cover property (cmd_ok);
  c_boot: cover property ($rose(boot_done));
  c_err: cover property (acc && pslverr);
endmodule : acm_core_chk

bind acm_core acm_core_chk acm_core_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .flags(flags), .rom_region(rom_region),
  .boot_done(boot_done), .nonlinearity_gain_field(nonlinearity_gain_field));

// file: tb/tb_acm_core.sv
// Directed APB bench for the accumulator core
`timescale 1ns/1ps
`include "acm_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_acm_core;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  acm_pkg::acm_flags_s flags;
  logic rom_region;
  logic boot_done;
  logic [7:0] nonlinearity_gain_field;
  logic [31:0] rd;
  logic last_err;
  logic [12:0] jx [4] = '{13'h100, 13'h201, 13'h202, 13'h202};
  int failures = 0;
  int checks = 0;

  always #12.5 pclk = ~pclk;

  acm_core acm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flags(flags), .rom_region(rom_region), .boot_done(boot_done),
    .nonlinearity_gain_field(nonlinearity_gain_field));

  // --------
  // Tasks
  // --------
  function automatic logic [7:0] bt(input int i);
    return 8'h90 + 8'(i);
  endfunction : bt

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk

  task automatic op(input acm_pkg::acm_op_e o, input logic [1:0] dst, input logic [1:0] src,
                    input logic [23:0] imm);
    wr(`ACM_OFS_IMM, {8'h00, imm});
    wr(`ACM_OFS_CMD, {23'h0, src, dst, o});
  endtask : op

  task automatic ramchk(input logic [6:0] p, input logic [23:0] e);
    op(acm_pkg::ACM_OP_PTR_LD, 2'd0, 2'd0, {17'h0, p});
    rdchk(`ACM_OFS_ACC_RAM, {8'h00, e});
  endtask : ramchk

  task automatic alu(input acm_pkg::acm_op_e o, input logic [1:0] dst, input logic [1:0] src,
                     input logic [23:0] imm, input logic [23:0] e, input logic [3:0] fl);
    op(o, dst, src, imm);
    rdchk(dst == 2'd3 ? `ACM_OFS_ACC_RAM : {8'h00, dst, 2'b00} + 12'h008, {8'h00, e});
    rdchk(`ACM_OFS_FLAGS, {28'h0, fl});
  endtask : alu

  task automatic boot;
    int n;
    n = 0;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wr(`ACM_OFS_CMD, 32'h0000_0009);
    `CHK(last_err, 1'b1)
    while (boot_done !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    `CHK(boot_done, 1'b1)
  endtask : boot

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // --------
  // Tests
  // --------
  initial begin
    boot;
    for (int a = 8; a <= 24; a += 4) rdchk(12'(a), 32'h0);
    rdchk(`ACM_OFS_PC, 32'd48);
    rdchk(`ACM_OFS_STATUS, 32'h1);
    op(acm_pkg::ACM_OP_PTR_LD, 2'd0, 2'd0, 24'd22);
    xfer(1'b0, `ACM_OFS_ACC_RAM, 32'h0);
    `CHK(rd[19:15], `ACM_CAUSE_POWER)
    xfer(1'b0, 12'h1fc, 32'h0);
    `CHK({last_err, rd}, {1'b1, 32'h0})
    $display("test reset done");
    // Copy source, plus a word the copy must skip
    for (int i = 0; i < 48; i++) begin
      wr(`ACM_OFS_NVM_ADDR, 32'(i));
      wr(`ACM_OFS_NVM_DATA, {24'h0, bt(i)});
    end
    op(acm_pkg::ACM_OP_PTR_LD, 2'd0, 2'd0, 24'd61);
    op(acm_pkg::ACM_OP_LDI, 2'd3, 2'd0, 24'h5a5a5a);
    boot;
    for (int k = 0; k < 16; k++) begin
      ramchk(7'(k < 13 ? 48 + k : 51 + k), {bt(3 * k), bt(3 * k + 1), bt(3 * k + 2)});
    end
    ramchk(7'd61, 24'h5a5a5a);
    rdchk(`ACM_OFS_CFG18, {8'h00, bt(45), bt(46), bt(47)});
    `CHK(nonlinearity_gain_field, bt(45))
    wr(`ACM_OFS_CFG18, 32'h0012_3456);
    ramchk(7'd66, 24'h123456);
    `CHK(nonlinearity_gain_field, 8'h12)
    $display("test copy done");
    op(acm_pkg::ACM_OP_PTR_LD, 2'd0, 2'd0, 24'h00007f);
    rdchk(`ACM_OFS_PTR, 32'd126);
    op(acm_pkg::ACM_OP_PTR_INC, 2'd0, 2'd0, 24'h0);
    rdchk(`ACM_OFS_PTR, 32'd0);
    op(acm_pkg::ACM_OP_PTR_DEC, 2'd0, 2'd0, 24'h0);
    rdchk(`ACM_OFS_PTR, 32'd126);
    op(acm_pkg::ACM_OP_PTR_LD, 2'd0, 2'd0, 24'd5);
    op(acm_pkg::ACM_OP_LDI, 2'd3, 2'd0, 24'h111111);
    op(acm_pkg::ACM_OP_PTR_INC, 2'd0, 2'd0, 24'h0);
    op(acm_pkg::ACM_OP_LDI, 2'd3, 2'd0, 24'h222222);
    op(acm_pkg::ACM_OP_PTR_DEC, 2'd0, 2'd0, 24'h0);
    rdchk(`ACM_OFS_ACC_RAM, 32'h111111);
    op(acm_pkg::ACM_OP_PTR_INC, 2'd0, 2'd0, 24'h0);
    rdchk(`ACM_OFS_ACC_RAM, 32'h222222);
    $display("test pointer done");
    alu(acm_pkg::ACM_OP_LDI, 2'd0, 2'd0, 24'h7fffff, 24'h7fffff, 4'b0000);
    alu(acm_pkg::ACM_OP_LDI, 2'd1, 2'd0, 24'h000001, 24'h000001, 4'b0000);
    alu(acm_pkg::ACM_OP_ADD, 2'd0, 2'd1, 24'h0, 24'h800000, 4'b0110);
    alu(acm_pkg::ACM_OP_LDI, 2'd2, 2'd0, 24'h0, 24'h0, 4'b0101);
    alu(acm_pkg::ACM_OP_SUB, 2'd2, 2'd1, 24'h0, 24'hffffff, 4'b1010);
    alu(acm_pkg::ACM_OP_MOVE, 2'd3, 2'd1, 24'h0, 24'h000001, 4'b1000);
    alu(acm_pkg::ACM_OP_ADD, 2'd3, 2'd0, 24'h0, 24'h800001, 4'b0010);
    alu(acm_pkg::ACM_OP_SHR, 2'd3, 2'd0, 24'h0, 24'hc00000, 4'b1010);
    alu(acm_pkg::ACM_OP_SHL, 2'd0, 2'd0, 24'h0, 24'h000000, 4'b1101);
    alu(acm_pkg::ACM_OP_ROR, 2'd1, 2'd0, 24'h0, 24'h800000, 4'b1010);
    alu(acm_pkg::ACM_OP_LDI, 2'd0, 2'd0, 24'h000003, 24'h000003, 4'b1000);
    alu(acm_pkg::ACM_OP_MUL, 2'd0, 2'd2, 24'h0, 24'hfffffd, 4'b1010);
    alu(acm_pkg::ACM_OP_SWAP, 2'd0, 2'd1, 24'h0, 24'h800000, 4'b1010);
    rdchk(`ACM_OFS_ACC_Y, 32'h00fffffd);
    $display("test alu done");
    op(acm_pkg::ACM_OP_JUMP, 2'd0, 2'd0, 24'h000100);
    for (int s = 0; s < 4; s++) begin
      op(acm_pkg::ACM_OP_JCOND, 2'd0, 2'(s), 24'(32'h200 + s));
      rdchk(`ACM_OFS_PC, {19'h0, jx[s]});
    end
    op(acm_pkg::ACM_OP_JUMP, 2'd0, 2'd0, 24'h000900);
    rdchk(`ACM_OFS_STATUS, 32'h3);
    op(acm_pkg::ACM_OP_ENTER, 2'd0, 2'd0, 24'h000004);
    rdchk(`ACM_OFS_PC, 32'd48);
    op(acm_pkg::ACM_OP_PTR_LD, 2'd0, 2'd0, 24'd22);
    xfer(1'b0, `ACM_OFS_ACC_RAM, 32'h0);
    `CHK(rd[19:15], 5'h04)
    op(acm_pkg::ACM_OP_ENTER, 2'd0, 2'd0, 24'h000008);
    xfer(1'b0, `ACM_OFS_ACC_RAM, 32'h0);
    `CHK(rd[19:15], 5'h04)
    $display("test jump done");
    op(acm_pkg::ACM_OP_LDI, 2'd0, 2'd0, 24'habcdef);
    op(acm_pkg::ACM_OP_PUT, 2'd0, 2'd0, 24'h00000f);
    op(acm_pkg::ACM_OP_GET, 2'd1, 2'd0, 24'h00000f);
    rdchk(`ACM_OFS_ACC_Y, 32'h00abcdef);
    wr(`ACM_OFS_NVM_ADDR, 32'd2045);
    rdchk(`ACM_OFS_NVM_DATA, 32'h0000_00ab);
    $display("test user cells done");
    print_verdict;
  end

  // Whole run needs about nine hundred cycles
  initial begin
    #500us;
    failures++;
    print_verdict;
  end
endmodule : tb_acm_core
